// ===== rtl/overlay_mix_control.sv
// Overlay mix control: picks normal video, overlay or re-weighted video per pixel.
`timescale 1ns/1ps
`default_nettype none

module overlay_mix_control
  import overlay_mix_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR = DEVICE_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Serial control port, open drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Main video and clamp, pixel rate on sys_clk
  input wire rgb_type video_in,
  input wire logic clamp_pulse,
  input wire logic [6:0] main_contrast,
  // Overlay source
  input wire logic overlay_gate_input,
  input wire logic [2:0] overlay_digital,
  input wire rgb_type overlay_analog,
  // Mixed output
  output rgb_type rgb_out,
  output logic analog_select
);

  state_type st;
  state_type next_st;

  logic [2:0][7:0] video_arr;
  logic [2:0][7:0] overlay_arr;
  logic [2:0][7:0] mixed;
  logic [1:0] overlay_level;
  logic transparent_background;
  logic bypass;
  logic [7:0] level_pct;
  logic [7:0] analog_pct;

  assign video_arr = video_in;
  assign overlay_arr = overlay_analog;
  assign overlay_level = st.control[LEVEL_LSB +: 2];
  assign transparent_background = st.control[TRANSPARENT_BIT];
  assign bypass = st.control[BYPASS_BIT];
  assign analog_select = st.control[ANALOG_SELECT_BIT];

  always_comb begin
    case (overlay_level)
      2'b00: level_pct = LEVEL_PCT_0;
      2'b01: level_pct = LEVEL_PCT_1;
      2'b10: level_pct = LEVEL_PCT_2;
      default: level_pct = LEVEL_PCT_3;
    endcase
  end

  assign analog_pct = bypass ? FULL_PCT : level_pct;

  function automatic logic [7:0] sub_sat(input logic [7:0] a, input logic [7:0] b);
    sub_sat = (a > b) ? 8'(a - b) : 8'h00;
  endfunction

  function automatic logic [7:0] gain(input logic [7:0] v, input logic [6:0] g);
    logic [15:0] p;
    p = 16'(v) * 16'(g);
    gain = p[GAIN_SHIFT +: 8];
  endfunction

  function automatic logic [7:0] pct(input logic [7:0] v, input logic [7:0] p);
    logic [15:0] q;
    q = (16'(v) * 16'(p)) / 16'(FULL_PCT);
    pct = q[7:0];
  endfunction

  for (genvar c = 0; c < 3; c++) begin : g_chan
    logic [7:0] vid;
    logic [7:0] ovl;
    logic [7:0] normal;
    logic [7:0] digital_bg;
    // both inputs use black levels caught in the clamp interval
    assign vid = sub_sat(video_arr[c], st.video_black[c]);
    assign ovl = sub_sat(overlay_arr[c], st.overlay_black[c]);
    assign normal = gain(vid, main_contrast);
    // transparent background uses the background contrast gain
    // the single gain serves highlight and transparent background alike
    assign digital_bg = transparent_background ? gain(vid, st.bg_contrast) : 8'h00;

    // combinational decode of gate, mode and level
    always_comb begin
      // gate low means normal video with no overlay share
      if (!overlay_gate_input) begin
        mixed[c] = normal;
      // analog overlay only while gate high
      // transparent bit and background gain ignored here
      end else if (analog_select) begin
        mixed[c] = pct(ovl, analog_pct);
      // opaque background is black, foreground from overlay
      end else if (overlay_digital[c]) begin
        mixed[c] = pct(FULL_SCALE, level_pct);
      end else begin
        mixed[c] = digital_bg;
      end
    end
  end

  logic scl_n;
  logic sda_n;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] read_value;

  always_comb begin
    scl_n = (st.scl_sync[1] == st.scl_sync[2]) ? st.scl_sync[2] : st.scl_f;
    sda_n = (st.sda_sync[1] == st.sda_sync[2]) ? st.sda_sync[2] : st.sda_f;
    scl_rise = scl_n & ~st.scl_f;
    scl_fall = ~scl_n & st.scl_f;
    start_cond = st.scl_f & scl_n & st.sda_f & ~sda_n;
    stop_cond = st.scl_f & scl_n & ~st.sda_f & sda_n;
    case (st.index)
      REG_BACKGROUND_CONTRAST: read_value = {1'b0, st.bg_contrast} & CONTRAST_MASK;
      REG_OVERLAY_CONTROL: read_value = st.control & CONTROL_MASK;
      default: read_value = 8'h00;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.scl_sync = {st.scl_sync[1:0], scl_in};
    next_st.sda_sync = {st.sda_sync[1:0], sda_in};
    next_st.scl_f = scl_n;
    next_st.sda_f = sda_n;
    next_st.rgb = mixed;
    // clamp both video and analog overlay in one interval
    if (clamp_pulse) begin
      next_st.video_black = video_arr;
      next_st.overlay_black = overlay_arr;
    end
    if (scl_rise && st.bus != st_idle) begin
      next_st.shreg = {st.shreg[6:0], sda_n};
      next_st.cnt = 4'(st.cnt + 4'h1);
    end
    if (start_cond) begin
      next_st.bus = st_dev;
      next_st.cnt = 4'h0;
      next_st.drive = 1'b0;
    end else if (stop_cond) begin
      next_st.bus = st_idle;
      next_st.drive = 1'b0;
    end else if (scl_fall) begin
      case (st.bus)
        st_dev: begin
          if (st.cnt == BITS_PER_BYTE) begin
            if (st.shreg[7:1] == DEVICE_ADDR) begin
              next_st.bus = st_dev_ack;
              next_st.rw = st.shreg[0];
              next_st.drive = 1'b1;
            end else begin
              next_st.bus = st_idle;
            end
          end
        end
        st_dev_ack, st_read_ack: begin
          next_st.cnt = 4'h0;
          if (st.bus == st_read_ack && st.shreg[0]) begin
            next_st.bus = st_idle;
            next_st.drive = 1'b0;
          end else if (st.rw) begin
            next_st.bus = st_read;
            next_st.tx = read_value;
            next_st.drive = ~read_value[7];
          end else begin
            next_st.bus = st_index;
            next_st.drive = 1'b0;
          end
        end
        st_index: begin
          if (st.cnt == BITS_PER_BYTE) begin
            next_st.index = st.shreg;
            next_st.bus = st_index_ack;
            next_st.drive = 1'b1;
          end
        end
        st_index_ack, st_write_ack: begin
          next_st.bus = st_write;
          next_st.cnt = 4'h0;
          next_st.drive = 1'b0;
        end
        st_write: begin
          if (st.cnt == BITS_PER_BYTE) begin
            // software loads mode and gain here; the block just stores them
            if (st.index == REG_BACKGROUND_CONTRAST) begin
              next_st.bg_contrast = st.shreg[6:0];
            end else if (st.index == REG_OVERLAY_CONTROL) begin
              next_st.control = st.shreg & CONTROL_MASK;
            end
            next_st.index = 8'(st.index + 8'h01);
            next_st.bus = st_write_ack;
            next_st.drive = 1'b1;
          end
        end
        st_read: begin
          if (st.cnt == BITS_PER_BYTE) begin
            next_st.bus = st_read_ack;
            next_st.index = 8'(st.index + 8'h01);
            next_st.drive = 1'b0;
          end else begin
            next_st.tx = {st.tx[6:0], 1'b0};
            next_st.drive = ~st.tx[6];
          end
        end
        default: begin
          next_st.bus = st_idle;
          next_st.drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.scl_sync <= 3'b111;
      st.sda_sync <= 3'b111;
      st.scl_f <= 1'b1;
      st.sda_f <= 1'b1;
      st.bus <= st_idle;
      st.bg_contrast <= BACKGROUND_CONTRAST_RESET;
      st.control <= OVERLAY_CONTROL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = ~st.drive;
  assign rgb_out = st.rgb;

endmodule

`default_nettype wire

// ===== rtl/overlay_mix_pkg.sv
// Constants and types shared by the overlay mix control block.
package overlay_mix_pkg;

  // Register indices on the serial control port.
  localparam logic [7:0] REG_BACKGROUND_CONTRAST = 8'h0a;
  localparam logic [7:0] REG_OVERLAY_CONTROL = 8'h0b;

  // Reset values.
  localparam logic [6:0] BACKGROUND_CONTRAST_RESET = 7'h00;
  localparam logic [7:0] OVERLAY_CONTROL_RESET = 8'h02;

  // Overlay control field positions and the mask of implemented bits.
  localparam int LEVEL_LSB = 0;
  localparam int TRANSPARENT_BIT = 3;
  localparam int ANALOG_SELECT_BIT = 4;
  localparam int BYPASS_BIT = 5;
  localparam logic [7:0] CONTROL_MASK = 8'hbb;
  localparam logic [7:0] CONTRAST_MASK = 8'h7f;

  // Overlay amplitudes in percent of full video amplitude.
  localparam logic [7:0] LEVEL_PCT_0 = 8'h37;
  localparam logic [7:0] LEVEL_PCT_1 = 8'h41;
  localparam logic [7:0] LEVEL_PCT_2 = 8'h4b;
  localparam logic [7:0] LEVEL_PCT_3 = 8'h55;
  localparam logic [7:0] FULL_PCT = 8'h64;
  localparam logic [7:0] FULL_SCALE = 8'hff;

  // Gain registers are 7-bit fractions of 128.
  localparam int GAIN_SHIFT = 7;

  // Serial port slave address; the value is arbitrary.
  localparam logic [6:0] DEVICE_ADDR_DEFAULT = 7'h5d;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    st_idle, st_dev, st_dev_ack, st_index, st_index_ack,
    st_write, st_write_ack, st_read, st_read_ack
  } bus_state_type;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } rgb_type;

  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic scl_f;
    logic sda_f;
    bus_state_type bus;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [7:0] index;
    logic rw;
    logic drive;
    logic [6:0] bg_contrast;
    logic [7:0] control;
    logic [2:0][7:0] video_black;
    logic [2:0][7:0] overlay_black;
    logic [2:0][7:0] rgb;
  } state_type;

endpackage

// ===== tb/osd_source.sv
// Model of the overlay source driving the gate and overlay colour pins.
`timescale 1ns/1ps
`default_nettype none
module osd_source
  import overlay_mix_pkg::*;
(
  // Bench command {enable, highlight, colour bits} and analog level
  input wire logic sys_clk,
  input wire logic [4:0] cmd,
  input wire rgb_type lvl,
  // Overlay pins
  output var logic gate,
  output var logic [2:0] dig,
  output var rgb_type ana
);
  initial begin
    gate = 1'b0;
    dig = 3'h0;
    ana = '0;
  end
  // Colour bits toggle outside the gate, so a leak through the gate shows up.
  always @(posedge sys_clk) begin
    gate <= cmd[4];
    dig <= !cmd[4] ? ~dig : (cmd[3] ? 3'h0 : cmd[2:0]);
    ana <= cmd[4] ? lvl : '0;
  end
endmodule
`default_nettype wire

// ===== tb/overlay_mix_control_bench.sv
// Self-checking bench for the overlay mix control block.
`timescale 1ns/1ps
`default_nettype none
module overlay_mix_control_bench;
  import overlay_mix_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [6:0] bg;
    logic [4:0] cmd;
    logic [7:0] ana;
    logic [23:0] want;
  } row_type;
  // row 5 highlights with contrast above the main gain
  row_type rows [12] = '{'{8'h02, 7'h00, 5'h00, 8'h00, 24'h404040},
    '{8'h02, 7'h00, 5'h15, 8'h00, 24'hbf00bf}, '{8'h00, 7'h00, 5'h17, 8'h00, 24'h8c8c8c},
    '{8'h01, 7'h00, 5'h17, 8'h00, 24'ha5a5a5}, '{8'h03, 7'h00, 5'h17, 8'h00, 24'hd8d8d8},
    '{8'h08, 7'h7f, 5'h1f, 8'h00, 24'h7f7f7f}, '{8'h0a, 7'h7f, 5'h14, 8'h00, 24'hbf7f7f},
    '{8'h10, 7'h00, 5'h10, 8'h64, 24'h373737}, '{8'h18, 7'h7f, 5'h10, 8'h64, 24'h373737},
    '{8'h13, 7'h00, 5'h10, 8'h64, 24'h555555}, '{8'h33, 7'h00, 5'h10, 8'h64, 24'h646464},
    '{8'h33, 7'h00, 5'h07, 8'h64, 24'h404040}};
  logic sys_clk, nrst, scl, sda_drv, sda_line, sda_out, sda_oe_n, clamp_pulse, analog_select;
  logic gate;
  logic [4:0] cmd;
  logic [2:0] dig;
  logic [7:0] rx, got;
  rgb_type video_in, lvl, ana, rgb_out;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  assign sda_line = sda_drv & (sda_oe_n | sda_out);
  overlay_mix_control uut (.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .video_in(video_in), .clamp_pulse(clamp_pulse),
    .main_contrast(7'h40), .overlay_gate_input(gate), .overlay_digital(dig),
    .overlay_analog(ana), .rgb_out(rgb_out), .analog_select(analog_select));
  osd_source osd (.sys_clk(sys_clk), .cmd(cmd), .lvl(lvl), .gate(gate), .dig(dig), .ana(ana));
  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task check(input logic [23:0] seen, input logic [23:0] want, input string what);
    samples_checked++;
    if (seen !== want) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task sbit(input logic b, input logic ack);
    sda_drv <= b;
    tick(6);
    scl <= 1'b1;
    tick(6);
    rx = {rx[6:0], sda_line};
    if (ack) check(24'(sda_line), 24'h0, "ack");
    scl <= 1'b0;
    tick(6);
  endtask
  task sbyte(input logic [7:0] tx, input logic ack);
    for (int i = 7; i >= 0; i--) sbit(tx[i], 1'b0);
    got = rx;
    sbit(1'b1, ack);
  endtask
  task frame(input logic stop);
    tick(1);
    // Data moves only while the clock is low, or as the start or stop edge itself.
    sda_drv <= stop ? 1'b0 : 1'b1;
    tick(6);
    scl <= 1'b1;
    tick(6);
    sda_drv <= stop;
    tick(6);
    scl <= stop;
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] val);
    frame(1'b0);
    sbyte({DEVICE_ADDR_DEFAULT, 1'b0}, 1'b1);
    sbyte(idx, 1'b1);
    sbyte(val, 1'b1);
    frame(1'b1);
  endtask
  task rd(input logic [7:0] idx);
    frame(1'b0);
    sbyte({DEVICE_ADDR_DEFAULT, 1'b0}, 1'b1);
    sbyte(idx, 1'b1);
    frame(1'b1);
    frame(1'b0);
    sbyte({DEVICE_ADDR_DEFAULT, 1'b1}, 1'b1);
    sbyte(8'hff, 1'b0);
    frame(1'b1);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    {nrst, scl, sda_drv, clamp_pulse, cmd, video_in, lvl} = {4'h7, 5'h0, 48'h0};
    tick(20);
    nrst <= 1'b1;
    tick(3);
    clamp_pulse <= 1'b0;
    foreach (rows[i]) begin
      wr(REG_OVERLAY_CONTROL, rows[i].ctrl);
      wr(REG_BACKGROUND_CONTRAST, {1'b0, rows[i].bg});
      video_in <= 24'h808080;
      cmd <= rows[i].cmd;
      lvl <= {3{rows[i].ana}};
      tick(4);
      @(negedge sys_clk);
      check(rgb_out, rows[i].want, "pixel");
      check(24'(analog_select), 24'(rows[i].ctrl[4]), "mode");
      $display("row %0d done", i);
    end
    tick(1);
    video_in <= 24'h202020;
    clamp_pulse <= 1'b1;
    tick(1);
    clamp_pulse <= 1'b0;
    tick(3);
    @(negedge sys_clk);
    check(rgb_out, 24'h0, "clamped black");
    tick(1);
    video_in <= 24'h606060;
    tick(3);
    @(negedge sys_clk);
    check(rgb_out, 24'h202020, "clamped video");
    tick(1);
    cmd <= 5'h10;
    lvl <= 24'h303030;
    tick(2);
    clamp_pulse <= 1'b1;
    tick(1);
    clamp_pulse <= 1'b0;
    lvl <= 24'h707070;
    tick(3);
    @(negedge sys_clk);
    check(rgb_out, 24'h404040, "clamped overlay");
    $display("clamp test done");
    tick(1);
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    @(negedge sys_clk);
    check(24'(analog_select), 24'h0, "mode after reset");
    rd(REG_OVERLAY_CONTROL);
    check(24'(got), 24'(OVERLAY_CONTROL_RESET), "control reset");
    wr(REG_OVERLAY_CONTROL, 8'hff);
    rd(REG_OVERLAY_CONTROL);
    check(24'(got), 24'hbb, "control mask");
    wr(REG_BACKGROUND_CONTRAST, 8'hff);
    rd(REG_BACKGROUND_CONTRAST);
    check(24'(got), 24'h7f, "contrast mask");
    $display("register test done");
    summarize();
  end
endmodule
`default_nettype wire

// ===== tb/overlay_mix_monitor.sv
// Concurrent checks on the ports of the overlay mix control block.
`timescale 1ns/1ps
`default_nettype none
module overlay_mix_monitor
  import overlay_mix_pkg::*;
(
  // Watched ports
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic sda_oe_n,
  input wire rgb_type video_in,
  input wire logic clamp_pulse,
  input wire logic overlay_gate_input,
  input wire logic [2:0] overlay_digital,
  input wire rgb_type overlay_analog,
  input wire rgb_type rgb_out,
  input wire logic analog_select
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  logic dmode, dred, dblue, dbg, dall, amode;
  assign dmode = overlay_gate_input && !analog_select;
  assign dred = dmode && overlay_digital[2];
  assign dblue = dmode && overlay_digital[0];
  assign dbg = dmode && !overlay_digital[1];
  assign dall = dmode && overlay_digital == 3'h7;
  assign amode = overlay_gate_input && analog_select;
  property p_gate_low;
    !$past(overlay_gate_input) |-> rgb_out.red <= $past(video_in.red);
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("gate low output too big");
  property p_dig_red;
    $past(dred) |-> rgb_out.red inside {8'h8c, 8'ha5, 8'hbf, 8'hd8};
  endproperty
  a_dig_red: assert property (p_dig_red) else $error("red overlay level");
  property p_dig_blue;
    $past(dblue) |-> rgb_out.blue inside {8'h8c, 8'ha5, 8'hbf, 8'hd8};
  endproperty
  a_dig_blue: assert property (p_dig_blue) else $error("blue overlay level");
  property p_dig_bg;
    $past(dbg) |-> rgb_out.green <= $past(video_in.green);
  endproperty
  a_dig_bg: assert property (p_dig_bg) else $error("background above video");
  property p_analog;
    $past(amode) |-> rgb_out.red <= $past(overlay_analog.red);
  endproperty
  a_analog: assert property (p_analog) else $error("analog overlay too big");
  property p_clamp;
    $past(clamp_pulse, 2) && $past(video_in) == $past(video_in, 2) &&
      !$past(overlay_gate_input) |-> rgb_out == '0;
  endproperty
  a_clamp: assert property (p_clamp) else $error("black level not removed");
  property p_equal;
    $past(dall) |-> rgb_out.red == rgb_out.green && rgb_out.green == rgb_out.blue;
  endproperty
  a_equal: assert property (p_equal) else $error("channels differ");
  property p_reset_mode;
    $rose(nrst) |-> !analog_select;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode after reset");
  property p_select;
    $changed(analog_select) |-> !sda_oe_n || !$past(sda_oe_n) || !$past(sda_oe_n, 2);
  endproperty
  a_select: assert property (p_select) else $error("mode change without write");
  c_analog: cover property ($past(amode));
  c_highlight: cover property (dmode && overlay_digital == 3'h0);
  c_clamp: cover property ($fell(clamp_pulse));
endmodule
bind overlay_mix_control overlay_mix_monitor mon (.sys_clk(sys_clk), .nrst(nrst),
  .sda_oe_n(sda_oe_n), .video_in(video_in), .clamp_pulse(clamp_pulse),
  .overlay_gate_input(overlay_gate_input), .overlay_digital(overlay_digital),
  .overlay_analog(overlay_analog), .rgb_out(rgb_out), .analog_select(analog_select));
`default_nettype wire
